/* src/udr_top.sv */
`timescale 1ns/1ns
`include "udr_consts.svh"
module udr_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             receiver_irq_pending
);
    import udr_pkg::*;

    function automatic udr_sel_e udr_decode(input logic [31:0] a);
        case (a[11:0])
            `UDR_ADDR_DATA: udr_decode = UDR_SEL_DATA;
            `UDR_ADDR_STAT: udr_decode = UDR_SEL_STAT;
            `UDR_ADDR_CTRL: udr_decode = UDR_SEL_CTRL;
            `UDR_ADDR_DIVH: udr_decode = UDR_SEL_DIVH;
            `UDR_ADDR_DIVL: udr_decode = UDR_SEL_DIVL;
            default:        udr_decode = UDR_SEL_NONE;
        endcase
        if (a[31:12] != 20'h00000)
        begin
            udr_decode = UDR_SEL_NONE;
        end
    endfunction

    logic          aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [31:0]   awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
    logic [3:0]    wstrb_ff, nxt_wstrb;
    logic          awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic          bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
    logic          rvalid_ff, nxt_rvalid;
    logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0]   rdata_ff, nxt_rdata;
    logic [2:0]    ctrl_ff, nxt_ctrl;
    logic [15:0]   div_ff, nxt_div;
    logic          pend_ff, nxt_pend, mp_ff, nxt_mp;
    logic [7:0]    rx_byte_ff, nxt_rx_byte;
    logic          do_wr, rd_data;
    logic [31:0]   wr_addr, wr_data;
    logic [3:0]    wr_strb;
    udr_sel_e      wr_sel, rd_sel;
    logic          tick;
    logic          tx_load;
    logic [10:0]   tx_sh_ff, nxt_tx_sh;
    logic [3:0]    tx_cnt_ff, nxt_tx_cnt;
    logic          tx_busy_ff, nxt_tx_busy, tx_out_ff, nxt_tx_out;

    // Bus write and read channels plus register side effects
    always_comb
    begin
        nxt_aw_got  = aw_got_ff | (s_axi_awvalid & awready_ff);
        nxt_w_got   = w_got_ff | (s_axi_wvalid & wready_ff);
        nxt_awaddr  = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : awaddr_ff;
        nxt_wdata   = (s_axi_wvalid & wready_ff) ? s_axi_wdata : wdata_ff;
        nxt_wstrb   = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : wstrb_ff;
        wr_addr     = nxt_awaddr;
        wr_data     = nxt_wdata;
        wr_strb     = nxt_wstrb;
        wr_sel      = udr_decode(wr_addr);
        do_wr       = nxt_aw_got & nxt_w_got & ~bvalid_ff;
        nxt_bvalid  = bvalid_ff & ~s_axi_bready;
        nxt_bresp   = bresp_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_div     = div_ff;
        tx_load     = 1'b0;
        if (do_wr)
        begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = (wr_sel == UDR_SEL_NONE) ? `UDR_RESP_ERR : `UDR_RESP_OK;
            if (wr_strb[0])
            begin
                case (wr_sel)
                    UDR_SEL_DATA: tx_load = 1'b1;
                    UDR_SEL_CTRL: nxt_ctrl = wr_data[2:0];
                    UDR_SEL_DIVH: nxt_div[15:8] = wr_data[7:0];
                    UDR_SEL_DIVL: nxt_div[7:0] = wr_data[7:0];
                    default:      nxt_ctrl = ctrl_ff;
                endcase
            end
        end
        nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
        nxt_wready  = ~nxt_w_got & ~nxt_bvalid;
        rd_sel      = udr_decode(s_axi_araddr);
        rd_data     = 1'b0;
        nxt_rvalid  = rvalid_ff & ~s_axi_rready;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (s_axi_arvalid & arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `UDR_RESP_OK;
            nxt_rdata  = 32'h00000000;
            case (rd_sel)
                UDR_SEL_DATA:
                begin
                    nxt_rdata[7:0] = rx_byte_ff;
                    rd_data        = 1'b1;
                end
                UDR_SEL_STAT:
                begin
                    nxt_rdata[`UDR_STAT_PEND] = pend_ff;
                    nxt_rdata[`UDR_STAT_MP]   = mp_ff;
                    nxt_rdata[`UDR_STAT_BUSY] = tx_busy_ff;
                end
                UDR_SEL_CTRL: nxt_rdata[2:0] = ctrl_ff;
                UDR_SEL_DIVH: nxt_rdata[7:0] = div_ff[15:8];
                UDR_SEL_DIVL: nxt_rdata[7:0] = div_ff[7:0];
                default:      nxt_rresp = `UDR_RESP_ERR;
            endcase
        end
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awaddr_ff  <= 32'h00000000;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `UDR_RESP_OK;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `UDR_RESP_OK;
            rdata_ff   <= 32'h00000000;
            ctrl_ff    <= `UDR_CTRL_RST;
            div_ff     <= `UDR_DIV_RST;
        end
        else
        begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
            ctrl_ff    <= nxt_ctrl;
            div_ff     <= nxt_div;
        end
    end

    // Bit-rate divider on the system clock
    udr_rate_div #(.W(16)) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .divisor (div_ff),
        .tick    (tick)
    );

    // Transmitter: start bit, eight data bits, optional mp bit, stop bit
    always_comb
    begin
        nxt_tx_sh   = tx_sh_ff;
        nxt_tx_cnt  = tx_cnt_ff;
        nxt_tx_busy = tx_busy_ff;
        nxt_tx_out  = tx_out_ff;
        if (tx_load && !tx_busy_ff)
        begin
            nxt_tx_busy = 1'b1;
            if (ctrl_ff[`UDR_CTRL_MPEN])
            begin
                nxt_tx_sh  = {1'b1, ctrl_ff[`UDR_CTRL_MPTX], wr_data[7:0], 1'b0};
                nxt_tx_cnt = `UDR_FRAME_LONG;
            end
            else
            begin
                nxt_tx_sh  = {2'b11, wr_data[7:0], 1'b0};
                nxt_tx_cnt = `UDR_FRAME_SHORT;
            end
        end
        else if (tx_busy_ff && tick)
        begin
            if (tx_cnt_ff == 4'h0)
            begin
                nxt_tx_busy = 1'b0;
                nxt_tx_out  = 1'b1;
            end
            else
            begin
                nxt_tx_out = tx_sh_ff[0];
                nxt_tx_sh  = {1'b1, tx_sh_ff[10:1]};
                nxt_tx_cnt = tx_cnt_ff - 4'h1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_sh_ff   <= 11'h7ff;
            tx_cnt_ff  <= 4'h0;
            tx_busy_ff <= 1'b0;
            tx_out_ff  <= 1'b1;
        end
        else
        begin
            tx_sh_ff   <= nxt_tx_sh;
            tx_cnt_ff  <= nxt_tx_cnt;
            tx_busy_ff <= nxt_tx_busy;
            tx_out_ff  <= nxt_tx_out;
        end
    end

    // Receiver: synchronise, find start edge, sample mid-bit
    logic           rx_s1_ff, rx_s2_ff, rx_s3_ff;
    udr_rx_state_e  rx_st_ff, nxt_rx_st;
    logic [15:0]    rx_tmr_ff, nxt_rx_tmr;
    logic [3:0]     rx_idx_ff, nxt_rx_idx;
    logic [7:0]     rx_sh_ff, nxt_rx_sh;
    logic           rx_mpb_ff, nxt_rx_mpb, rx_done;
    always_comb
    begin
        nxt_rx_st  = rx_st_ff;
        nxt_rx_tmr = rx_tmr_ff;
        nxt_rx_idx = rx_idx_ff;
        nxt_rx_sh  = rx_sh_ff;
        nxt_rx_mpb = rx_mpb_ff;
        rx_done    = 1'b0;
        case (rx_st_ff)
            UDR_RX_IDLE:
            begin
                if (rx_s3_ff && !rx_s2_ff)
                begin
                    nxt_rx_st  = UDR_RX_RUN;
                    nxt_rx_tmr = {1'b0, div_ff[15:1]};
                    nxt_rx_idx = 4'h0;
                    nxt_rx_mpb = 1'b0;
                end
            end
            UDR_RX_RUN:
            begin
                nxt_rx_tmr = rx_tmr_ff - 16'h0001;
                if (rx_tmr_ff == 16'h0000)
                begin
                    nxt_rx_tmr = div_ff - 16'h0001;
                    nxt_rx_idx = rx_idx_ff + 4'h1;
                    if (rx_idx_ff == 4'h0 && rx_s2_ff)
                    begin
                        nxt_rx_st = UDR_RX_IDLE;
                    end
                    else if (rx_idx_ff == (ctrl_ff[`UDR_CTRL_MPEN] ?
                             `UDR_RX_STOP_L : `UDR_RX_STOP_S))
                    begin
                        nxt_rx_st = UDR_RX_IDLE;
                        rx_done   = 1'b1;
                    end
                    else if (rx_idx_ff == `UDR_RX_MP_IDX)
                    begin
                        nxt_rx_mpb = rx_s2_ff;
                    end
                    else if (rx_idx_ff != 4'h0)
                    begin
                        nxt_rx_sh = {rx_s2_ff, rx_sh_ff[7:1]};
                    end
                end
            end
            default: nxt_rx_st = UDR_RX_IDLE;
        endcase
        nxt_rx_byte = rx_done ? rx_sh_ff : rx_byte_ff;
        // Set wins over the clear caused by a data read
        nxt_mp   = rx_done ? rx_mpb_ff : (mp_ff & ~rd_data);
        nxt_pend = rx_done | (ctrl_ff[`UDR_CTRL_RDIE] & tick)
                   | (pend_ff & ~rd_data);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_s1_ff   <= 1'b1;
            rx_s2_ff   <= 1'b1;
            rx_s3_ff   <= 1'b1;
            rx_st_ff   <= UDR_RX_IDLE;
            rx_tmr_ff  <= 16'h0000;
            rx_idx_ff  <= 4'h0;
            rx_sh_ff   <= 8'h00;
            rx_mpb_ff  <= 1'b0;
            rx_byte_ff <= 8'h00;
            mp_ff      <= 1'b0;
            pend_ff    <= 1'b0;
        end
        else
        begin
            rx_s1_ff   <= serial_in_pin;
            rx_s2_ff   <= rx_s1_ff;
            rx_s3_ff   <= rx_s2_ff;
            rx_st_ff   <= nxt_rx_st;
            rx_tmr_ff  <= nxt_rx_tmr;
            rx_idx_ff  <= nxt_rx_idx;
            rx_sh_ff   <= nxt_rx_sh;
            rx_mpb_ff  <= nxt_rx_mpb;
            rx_byte_ff <= nxt_rx_byte;
            mp_ff      <= nxt_mp;
            pend_ff    <= nxt_pend;
        end
    end

    assign s_axi_awready        = awready_ff;
    assign s_axi_wready         = wready_ff;
    assign s_axi_bvalid         = bvalid_ff;
    assign s_axi_bresp          = bresp_ff;
    assign s_axi_arready        = arready_ff;
    assign s_axi_rvalid         = rvalid_ff;
    assign s_axi_rresp          = rresp_ff;
    assign s_axi_rdata          = rdata_ff;
    assign serial_out_pin       = tx_out_ff;
    assign receiver_irq_pending = pend_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pend_on_tick: assert property (ctrl_ff[0] && tick |=> pend_ff)
        else $error("Reload with enable did not raise pending");
    a_div_high: assert property (do_wr && wr_strb[0] && wr_sel == UDR_SEL_DIVH
        |=> div_ff[15:8] == $past(wr_data[7:0]) && $stable(div_ff[7:0]))
        else $error("High divisor byte write wrong");
    a_mp_capture: assert property (rx_done |=> mp_ff == $past(rx_mpb_ff))
        else $error("Multiprocessor bit not captured");
    a_mp_clear: assert property (rd_data && !rx_done |=> !mp_ff)
        else $error("Data read did not clear multiprocessor bit");
    a_tx_start: assert property (tx_busy_ff && tick && tx_cnt_ff != 4'h0
        |=> tx_out_ff == $past(tx_sh_ff[0]))
        else $error("Serial bit not driven from the transmit shifter");
    a_shared_read: assert property (s_axi_arvalid && arready_ff && rd_sel == UDR_SEL_DATA
        |=> rvalid_ff && rdata_ff == {24'h000000, $past(rx_byte_ff)})
        else $error("Data address read did not return receive byte");
    a_rx_store: assert property (rx_done |=> rx_byte_ff == $past(rx_sh_ff))
        else $error("Received byte not stored");
    a_pend_read: assert property (pend_ff && rd_data && !rx_done && !(ctrl_ff[0] && tick)
        |=> !pend_ff)
        else $error("Pending not cleared by data read");
    a_bresp_pair: assert property (do_wr |=> s_axi_bvalid [*1] ##0 !awready_ff)
        else $error("Write response missing");
    c_write_tx: cover property (tx_load && !tx_busy_ff);
    c_rx_frame: cover property (rx_done);
    c_tick_irq: cover property (ctrl_ff[0] && tick);
    c_clear_race: cover property (rx_done && rd_data);
endmodule

/* include/udr_consts.svh */
`ifndef UDR_CONSTS_SVH
`define UDR_CONSTS_SVH
// Register byte offsets
`define UDR_ADDR_DATA   12'hf40
`define UDR_ADDR_STAT   12'hf44
`define UDR_ADDR_CTRL   12'hf48
`define UDR_ADDR_DIVH   12'hf4c
`define UDR_ADDR_DIVL   12'hf50
// Status bits
`define UDR_STAT_PEND   0
`define UDR_STAT_MP     1
`define UDR_STAT_BUSY   2
// Control bits
`define UDR_CTRL_RDIE   0
`define UDR_CTRL_MPEN   1
`define UDR_CTRL_MPTX   2
// Reset values, frame lengths, receive bit indices and response codes
`define UDR_DIV_RST     16'h0010
`define UDR_CTRL_RST    3'h0
`define UDR_FRAME_LONG  4'hb
`define UDR_FRAME_SHORT 4'ha
`define UDR_RX_STOP_L   4'ha
`define UDR_RX_STOP_S   4'h9
`define UDR_RX_MP_IDX   4'h9
`define UDR_RESP_OK     2'b00
`define UDR_RESP_ERR    2'b10
`endif

/* include/udr_pkg.sv */
package udr_pkg;
    typedef enum logic [2:0]
    {
        UDR_SEL_DATA = 3'b000,
        UDR_SEL_STAT = 3'b001,
        UDR_SEL_CTRL = 3'b010,
        UDR_SEL_DIVH = 3'b011,
        UDR_SEL_DIVL = 3'b100,
        UDR_SEL_NONE = 3'b111
    } udr_sel_e;

    typedef enum logic [0:0]
    {
        UDR_RX_IDLE = 1'b0,
        UDR_RX_RUN  = 1'b1
    } udr_rx_state_e;
endpackage

/* src/udr_rate_div.sv */
`timescale 1ns/1ns
`include "udr_consts.svh"
// Down counter that reloads from the divisor and pulses once per reload
module udr_rate_div #(
    parameter int W = 16
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic         tick_ff;
    logic         nxt_tick;

    // Count system clocks down, reload at the terminal value
    always_comb
    begin
        nxt_tick  = 1'b0;
        nxt_count = count_ff - {{(W-1){1'b0}}, 1'b1};
        if (count_ff <= {{(W-1){1'b0}}, 1'b1})
        begin
            nxt_count = divisor;
            nxt_tick  = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_ff <= W'(`UDR_DIV_RST);
            tick_ff  <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            tick_ff  <= nxt_tick;
        end
    end

    assign tick = tick_ff;

    a_tick_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_ff |-> count_ff == $past(divisor))
        else $error("Counter not reloaded with divisor on tick");
    a_tick_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_ff && count_ff > {{(W-1){1'b0}}, 1'b1} |=> !tick_ff)
        else $error("Rate ticks closer than the divisor allows");
endmodule

/* bench/udr_remote_model.sv */
`timescale 1ns/1ns
// Far-end serial device: sends frames to us and captures the frames we send
module udr_remote_model (
    input  wire logic aclk,
    input  wire logic rx_line,
    output logic      tx_line
);
    int         per = 16;
    logic       nine = 1'b0;
    logic [7:0] got;
    logic       got_mp;
    logic       got_stop;
    int         rx_cnt = 0;
    int         i;

    // Line idles high between frames
    initial tx_line = 1'b1;

    // One frame: start, data LSB first, optional mp bit, stop; called just after an edge
    task automatic send(input logic [7:0] b, input logic mp);
        logic [10:0] f;
        f = {1'b1, nine ? mp : 1'b1, b, 1'b0};
        for (int k = 0; k < (nine ? 11 : 10); k++)
        begin
            tx_line <= f[k];
            repeat (per) @(posedge aclk);
        end
    endtask

    // Capture: find start edge, sample mid-bit every period
    always
    begin
        @(negedge rx_line);
        repeat (per / 2) @(posedge aclk);
        if (rx_line === 1'b0)
        begin
            for (i = 0; i < 8; i++)
            begin
                repeat (per) @(posedge aclk);
                got[i] = rx_line;
            end
            got_mp = 1'b0;
            if (nine)
            begin
                repeat (per) @(posedge aclk);
                got_mp = rx_line;
            end
            repeat (per) @(posedge aclk);
            got_stop = rx_line;
            rx_cnt++;
        end
    end
endmodule

/* bench/tb_udr_top.sv */
`timescale 1ns/1ns
`include "udr_consts.svh"
module tb_udr_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, sin, sout, irq;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] d;
    logic [15:0] dv;
    logic [7:0]  b;
    logic [1:0]  k2;
    int          n_fail = 0, cmp_count = 0, cyc = 0, w, n0;

    always #5 aclk = ~aclk;

    udr_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_in_pin(sin), .serial_out_pin(sout),
        .receiver_irq_pending(irq));
    udr_remote_model i_remote (.aclk(aclk), .rx_line(sout), .tx_line(sin));

    task automatic conclude;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= {20'h0, a};
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= {20'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dat = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr_ok(input logic [11:0] a, input logic [31:0] dat);
        wr(a, dat, r);
        chk(32'(r), 32'(`UDR_RESP_OK), "write response");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        rd(a, d, r);
        chk(32'(r), 32'(`UDR_RESP_OK), "read response");
        chk(d, exp, what);
    endtask

    // Poll until the transmitter is idle again
    task automatic wait_idle;
        do rd(`UDR_ADDR_STAT, d, r); while (d[`UDR_STAT_BUSY] !== 1'b0);
    endtask

    initial
    begin
        void'($urandom(56));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(32'(sout), 32'h1, "idle line");
        chk(32'(irq), 32'h0, "pending after reset");
        rd_chk(`UDR_ADDR_DIVH, 32'h0, "divisor high reset");
        rd_chk(`UDR_ADDR_DIVL, 32'h10, "divisor low reset");
        // Transmit at several divisors, one of them using the high byte
        for (int k = 0; k < 3; k++)
        begin
            dv = (k == 0) ? 16'h0010 : (k == 1) ? 16'h0103 : 16'(8 + $urandom_range(0, 12));
            wr_ok(`UDR_ADDR_DIVH, {24'h0, dv[15:8]});
            wr_ok(`UDR_ADDR_DIVL, {24'h0, dv[7:0]});
            i_remote.per = int'(dv);
            b = (k == 0) ? 8'h55 : (8'($urandom) | 8'h01);
            n0 = i_remote.rx_cnt;
            wr_ok(`UDR_ADDR_DATA, {24'h0, b});
            do @(posedge aclk); while (sout !== 1'b0);
            w = 0;
            do
            begin
                @(posedge aclk);
                w++;
            end while (sout === 1'b0 && w < 1000);
            chk(32'(w), {16'h0, dv}, "start bit length");
            while (i_remote.rx_cnt == n0) @(posedge aclk);
            chk(32'({i_remote.got_stop, i_remote.got}), {23'h0, 1'b1, b}, "sent byte");
            wait_idle();
        end
        // Receive 8N1 and mp frames
        for (int k = 0; k < 4; k++)
        begin
            k2 = 2'(k);
            i_remote.nine = k2[1];
            wr_ok(`UDR_ADDR_CTRL, {30'h0, k2[1], 1'b0});
            b = 8'($urandom);
            i_remote.send(b, k2[0]);
            // Frame ends at mid-stop after the input sync, stop level unchecked, so let it settle
            repeat (4) @(posedge aclk);
            chk(32'(irq), 32'h1, "pending after byte");
            rd_chk(`UDR_ADDR_STAT, {30'h0, k2[0] & k2[1], 1'b1}, "status after byte");
            rd_chk(`UDR_ADDR_DATA, {24'h0, b}, "received byte");
            rd_chk(`UDR_ADDR_STAT, 32'h0, "status after read");
        end
        // Transmit a frame carrying an mp bit of one
        wr_ok(`UDR_ADDR_CTRL, 32'h6);
        n0 = i_remote.rx_cnt;
        b = 8'($urandom);
        wr_ok(`UDR_ADDR_DATA, {24'h0, b});
        while (i_remote.rx_cnt == n0) @(posedge aclk);
        chk(32'({i_remote.got_mp, i_remote.got}), {23'h0, 1'b1, b}, "mp frame sent");
        wait_idle();
        // Divider reloads raise pending only while enabled
        wr_ok(`UDR_ADDR_CTRL, 32'h1);
        rd(`UDR_ADDR_DATA, d, r);
        w = 0;
        while (irq !== 1'b1 && w < 100)
        begin
            @(posedge aclk);
            w++;
        end
        chk(32'(w <= int'(dv) + 2), 32'h1, "reload raises pending");
        rd_chk(`UDR_ADDR_STAT, 32'h1, "pending in status");
        wr_ok(`UDR_ADDR_CTRL, 32'h0);
        rd(`UDR_ADDR_DATA, d, r);
        repeat (3 * int'(dv)) @(posedge aclk);
        chk(32'(irq), 32'h0, "no pending when disabled");
        // Unmapped places answer with an error
        rd(12'hffc, d, r);
        chk(32'(r), 32'(`UDR_RESP_ERR), "unmapped read response");
        chk(d, 32'h0, "unmapped read data");
        wr(12'hf54, 32'h1, r);
        chk(32'(r), 32'(`UDR_RESP_ERR), "unmapped write");
        conclude();
    end
endmodule
